// File: src/odc_ctrl.sv
/*
 * Command interpreter of an octal serial-loaded DAC: shift register, command
 * decode, input and DAC registers, load and clear logic.
 * Assumes serial pins are asynchronous to mclk and slow against it (the
 * serial clock at least four mclk periods high and low).
 */
`timescale 1ns/100ps

// Contract
// - frame is 32 bits: 4 ignored, 4 command, 4 address, then data
// - frame-sync rising early drops the frame, changing no register
// - clear falling edge loads input and DAC registers with clear code
// - codes: 0101 clear code, 0100 power, 0110 mask, 1000 reference
// - reference enable from bit 0, off by default
// - reference frame stores only bit 0, other fields ignored
// - power mode bits 9..8: normal, 1k, 100k, three-state
// - power frame bits 7..0 select channels H..A for the mode
// - clear field: zero, midscale, full scale, or no operation
// - clear-code frame stores bits 1..0
// - synchronous load copies data on the 32nd falling clock edge
// - asynchronous mode: load pin fall copies unmasked input registers
// - software load command 0011 writes and updates one register; command 0010 writes one register and updates all
// - mask bit 0 channels update only on load pin request; commands 0001, 0010 and 0011 also update them
// - mask bit 1 channels update at once, ignoring the load pin
// - code 0110 loads 8-bit mask from bits 7..0
// - mask resets to all zeros
module odc_ctrl (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // serial link and control pins
    input wire logic sclk,
    input wire logic sync_n,
    input wire logic sdin,
    input wire logic load_dac_n,
    input wire logic clear_n,
    // control state
    output logic reference_enable_r,
    output logic [1:0] clear_code_select_r,
    output logic [odc_pkg::NUM_CH-1:0] load_override_mask_r,
    output logic [2*odc_pkg::NUM_CH-1:0] pwrdn_mode_r,
    output logic [odc_pkg::NUM_CH*odc_pkg::CODE_W-1:0] dac_code_r,
    output logic frame_done_r
);
    localparam int NCH = odc_pkg::NUM_CH;
    localparam int CW = odc_pkg::CODE_W;

    logic [2:0] sclk_s_r, sync_s_r, sdin_s_r, load_dac_n_s_r, clr_s_r;
    logic [odc_pkg::FRAME_BITS-1:0] shift_r;
    logic [odc_pkg::CNT_W-1:0] cnt_r;
    odc_pkg::odc_state_type state_r;
    odc_pkg::odc_frame_type frame;
    logic [CW-1:0] in_reg_r [NCH];
    logic sclk_fall, sync_rise, load_dac_n_fall, clr_fall, bit_last, commit;
    logic [odc_pkg::FRAME_BITS-1:0] full_word;
    logic [CW-1:0] clr_value;
    logic [NCH-1:0] ch_hit, in_wr, dac_upd, hw_upd;

    // two stages each, then an edge register read only past the second
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            // idle levels, so no false edge follows reset
            sclk_s_r <= 3'h7;
            sync_s_r <= 3'h7;
            sdin_s_r <= 3'h0;
            load_dac_n_s_r <= 3'h7;
            clr_s_r <= 3'h7;
        end else begin
            sclk_s_r <= {sclk_s_r[1:0], sclk};
            sync_s_r <= {sync_s_r[1:0], sync_n};
            sdin_s_r <= {sdin_s_r[1:0], sdin};
            load_dac_n_s_r <= {load_dac_n_s_r[1:0], load_dac_n};
            clr_s_r <= {clr_s_r[1:0], clear_n};
        end
    end

    // sdin read one stage deeper than the edge, from the sample taken just before it
    assign sclk_fall = sclk_s_r[2] & ~sclk_s_r[1];
    assign sync_rise = ~sync_s_r[2] & sync_s_r[1];
    assign load_dac_n_fall = load_dac_n_s_r[2] & ~load_dac_n_s_r[1];
    assign clr_fall = clr_s_r[2] & ~clr_s_r[1];
    assign bit_last = sclk_fall && (cnt_r == odc_pkg::LAST_BIT);
    assign full_word = {shift_r[odc_pkg::FRAME_BITS-2:0], sdin_s_r[2]};
    // a clear during a write aborts it
    assign commit = (state_r == odc_pkg::ST_SHIFT) && bit_last && !clr_fall
        && !sync_s_r[1];

    // frame shifter
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            state_r <= odc_pkg::ST_IDLE;
            cnt_r <= odc_pkg::CNT_ZERO;
            shift_r <= odc_pkg::SHIFT_RST;
        end else begin
            unique case (state_r)
                odc_pkg::ST_IDLE: begin
                    cnt_r <= odc_pkg::CNT_ZERO;
                    if (!sync_s_r[1]) begin
                        state_r <= odc_pkg::ST_SHIFT;
                    end
                end
                odc_pkg::ST_SHIFT: begin
                    if (sync_s_r[1] || clr_fall) begin
                        state_r <= sync_s_r[1] ? odc_pkg::ST_IDLE
                            : odc_pkg::ST_WAIT;
                        cnt_r <= odc_pkg::CNT_ZERO;
                        shift_r <= odc_pkg::SHIFT_RST;
                    end else if (sclk_fall) begin
                        shift_r <= full_word;
                        cnt_r <= cnt_r + odc_pkg::CNT_ONE;
                        if (bit_last) begin
                            state_r <= odc_pkg::ST_WAIT;
                        end
                    end
                end
                odc_pkg::ST_WAIT: begin
                    if (sync_s_r[1]) begin
                        state_r <= odc_pkg::ST_IDLE;
                    end
                end
            endcase
        end
    end

    always_comb begin
        frame.raw = full_word;
        frame.cmd = full_word[odc_pkg::CMD_HI:odc_pkg::CMD_LO];
        frame.addr = full_word[odc_pkg::ADDR_HI:odc_pkg::ADDR_LO];
        frame.data = full_word[odc_pkg::DATA_HI:odc_pkg::DATA_LO];
    end

    always_comb begin
        unique case (clear_code_select_r)
            odc_pkg::CLR_SEL_ZERO: clr_value = odc_pkg::CODE_ZERO;
            odc_pkg::CLR_SEL_MID: clr_value = odc_pkg::CODE_MID;
            odc_pkg::CLR_SEL_FULL: clr_value = odc_pkg::CODE_FULL;
            odc_pkg::CLR_SEL_NOP: clr_value = odc_pkg::CODE_ZERO;
        endcase
    end

    // per-channel write and update strobes
    genvar g;
    generate
        for (g = 0; g < NCH; g++) begin : g_ch
            assign ch_hit[g] = (frame.addr == 4'(g))
                || (frame.addr == odc_pkg::ADDR_ALL);
            assign in_wr[g] = commit && ch_hit[g]
                && (frame.cmd == odc_pkg::CMD_WRITE_IN
                || frame.cmd == odc_pkg::CMD_WRITE_UPD
                || frame.cmd == odc_pkg::CMD_WRITE_ALL);
            // masked channels see the load pin as tied low
            assign hw_upd[g] = load_dac_n_fall
                && !load_override_mask_r[g];
            assign dac_upd[g] = hw_upd[g]
                || (in_wr[g] && load_override_mask_r[g])
                || (in_wr[g] && !load_dac_n_s_r[1])
                || (commit && frame.cmd == odc_pkg::CMD_WRITE_ALL)
                || (commit && ch_hit[g]
                && (frame.cmd == odc_pkg::CMD_UPDATE_N
                || frame.cmd == odc_pkg::CMD_WRITE_UPD));

            always_ff @(posedge mclk) begin
                if (!rst_n) begin
                    in_reg_r[g] <= odc_pkg::CODE_ZERO;
                    dac_code_r[g*CW +: CW] <= odc_pkg::CODE_ZERO;
                    pwrdn_mode_r[2*g +: 2] <= odc_pkg::PD_NORMAL;
                end else begin
                    if (clr_fall
                        && clear_code_select_r != odc_pkg::CLR_SEL_NOP) begin
                        in_reg_r[g] <= clr_value;
                        dac_code_r[g*CW +: CW] <= clr_value;
                    end else begin
                        if (in_wr[g]) begin
                            in_reg_r[g] <= frame.data;
                        end
                        if (dac_upd[g]) begin
                            dac_code_r[g*CW +: CW] <= in_wr[g] ? frame.data
                                : in_reg_r[g];
                        end
                    end
                    if (commit && frame.cmd == odc_pkg::CMD_POWER
                        && frame.raw[odc_pkg::SEL_LO + g]) begin
                        pwrdn_mode_r[2*g +: 2] <=
                            frame.raw[odc_pkg::PD_HI:odc_pkg::PD_LO];
                    end
                end
            end
        end
    endgenerate

    // control registers
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            reference_enable_r <= odc_pkg::REF_RST;
            clear_code_select_r <= odc_pkg::CLR_RST;
            load_override_mask_r <= odc_pkg::MASK_RST;
            frame_done_r <= 1'b0;
        end else begin
            frame_done_r <= commit;
            if (commit) begin
                unique case (frame.cmd)
                    odc_pkg::CMD_REF: begin
                        reference_enable_r <=
                            frame.raw[odc_pkg::REF_BIT];
                    end
                    odc_pkg::CMD_CLR_CODE: begin
                        clear_code_select_r <=
                            frame.raw[odc_pkg::CLR_HI:odc_pkg::CLR_LO];
                    end
                    odc_pkg::CMD_MASK: begin
                        load_override_mask_r <=
                            frame.raw[odc_pkg::SEL_HI:odc_pkg::SEL_LO];
                    end
                    odc_pkg::CMD_RESET: begin
                        reference_enable_r <= odc_pkg::REF_RST;
                        clear_code_select_r <= odc_pkg::CLR_RST;
                        load_override_mask_r <= odc_pkg::MASK_RST;
                    end
                    default: begin
                    end
                endcase
            end
        end
    end
endmodule // odc_ctrl

// File: src/odc_pkg.sv
/*
 * Package for the octal DAC command interpreter: frame layout, command codes,
 * clear codes, power modes and the decoded frame carrier.
 * Assumes a 32-bit MSB-first frame shifted on falling serial clock edges.
 */
package odc_pkg;
    localparam int FRAME_BITS = 32;
    localparam int NUM_CH = 8;
    localparam int CODE_W = 16;
    localparam int CNT_W = 6;
    // frame field positions
    localparam int CMD_HI = 27;
    localparam int CMD_LO = 24;
    localparam int ADDR_HI = 23;
    localparam int ADDR_LO = 20;
    localparam int DATA_HI = 19;
    localparam int DATA_LO = 4;
    localparam int PD_HI = 9;
    localparam int PD_LO = 8;
    localparam int SEL_HI = 7;
    localparam int SEL_LO = 0;
    localparam int CLR_HI = 1;
    localparam int CLR_LO = 0;
    localparam int REF_BIT = 0;
    localparam logic [CNT_W-1:0] LAST_BIT = 6'h1f;
    localparam logic [CNT_W-1:0] CNT_ZERO = 6'h00;
    localparam logic [CNT_W-1:0] CNT_ONE = 6'h01;
    // command codes
    localparam logic [3:0] CMD_WRITE_IN = 4'h0;
    localparam logic [3:0] CMD_UPDATE_N = 4'h1;
    localparam logic [3:0] CMD_WRITE_ALL = 4'h2;
    localparam logic [3:0] CMD_SW_LOAD = 4'h3;
    localparam logic [3:0] CMD_WRITE_UPD = 4'h3;
    localparam logic [3:0] CMD_POWER = 4'h4;
    localparam logic [3:0] CMD_CLR_CODE = 4'h5;
    localparam logic [3:0] CMD_MASK = 4'h6;
    localparam logic [3:0] CMD_RESET = 4'h7;
    localparam logic [3:0] CMD_REF = 4'h8;
    localparam logic [3:0] ADDR_ALL = 4'hf;
    // clear code selections
    localparam logic [1:0] CLR_SEL_ZERO = 2'h0;
    localparam logic [1:0] CLR_SEL_MID = 2'h1;
    localparam logic [1:0] CLR_SEL_FULL = 2'h2;
    localparam logic [1:0] CLR_SEL_NOP = 2'h3;
    localparam logic [CODE_W-1:0] CODE_ZERO = 16'h0000;
    localparam logic [CODE_W-1:0] CODE_MID = 16'h8000;
    localparam logic [CODE_W-1:0] CODE_FULL = 16'hffff;
    // reset values
    localparam logic REF_RST = 1'h0;
    localparam logic [1:0] CLR_RST = 2'h0;
    localparam logic [NUM_CH-1:0] MASK_RST = 8'h00;
    localparam logic [NUM_CH-1:0] CH_NONE = 8'h00;
    localparam logic [NUM_CH-1:0] CH_ALL = 8'hff;
    localparam logic [FRAME_BITS-1:0] SHIFT_RST = 32'h0000_0000;

    typedef enum logic [1:0] {
        PD_NORMAL = 2'h0,
        PD_1K = 2'h1,
        PD_100K = 2'h2,
        PD_TRISTATE = 2'h3
    } odc_pwr_type;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_SHIFT = 3'b010,
        ST_WAIT = 3'b100
    } odc_state_type;

    typedef struct packed {
        logic [3:0] cmd;
        logic [3:0] addr;
        logic [CODE_W-1:0] data;
        logic [FRAME_BITS-1:0] raw;
    } odc_frame_type;
endpackage

// File: testbench/odc_ctrl_checker.sv
/* Checker for odc_ctrl: reset, commit timing and clear behaviour.
   Assumes the host holds frame sync low well past the last bit. */
`timescale 1ns/100ps
module odc_ctrl_checker (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // pins
    input wire logic sync_n,
    input wire logic load_dac_n,
    input wire logic clear_n,
    // state
    input wire logic reference_enable_r,
    input wire logic [1:0] clear_code_select_r,
    input wire logic [odc_pkg::NUM_CH-1:0] load_override_mask_r,
    input wire logic [2*odc_pkg::NUM_CH-1:0] pwrdn_mode_r,
    input wire logic [odc_pkg::NUM_CH*odc_pkg::CODE_W-1:0] dac_code_r,
    input wire logic frame_done_r
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    reset_vals_a: assert property (
        $rose(rst_n) |-> !reference_enable_r
        && load_override_mask_r == '0 && !frame_done_r)
        else $error("state not cleared by reset");
    done_pulse_a: assert property (
        frame_done_r |=> !frame_done_r)
        else $error("frame done longer than one cycle");
    // registers and the done pulse leave the same commit edge
    ref_commit_a: assert property (
        !$stable(reference_enable_r) |-> frame_done_r)
        else $error("reference changed outside a commit");
    mask_commit_a: assert property (
        !$stable(load_override_mask_r) |-> frame_done_r)
        else $error("mask changed outside a commit");
    code_commit_a: assert property (
        !$stable(clear_code_select_r) |-> frame_done_r)
        else $error("clear code changed outside a commit");
    power_commit_a: assert property (
        !$stable(pwrdn_mode_r) |-> frame_done_r)
        else $error("power mode changed outside a commit");
    sync_low_a: assert property (
        frame_done_r |-> !$past(sync_n, 8))
        else $error("commit without frame sync held low");
    dac_idle_a: assert property (
        (sync_n && clear_n && load_dac_n)[*8] |=> $stable(dac_code_r))
        else $error("dac changed with pins idle");
    clear_full_a: assert property (
        $fell(clear_n) && clear_code_select_r == odc_pkg::CLR_SEL_FULL
        |-> ##[1:8] dac_code_r == '1)
        else $error("clear to full scale missing");
    clear_nop_a: assert property (
        $fell(clear_n) && clear_code_select_r == odc_pkg::CLR_SEL_NOP
        |=> $stable(dac_code_r)[*6])
        else $error("no-op clear changed dac");
    cover property (frame_done_r);
    cover property ($fell(clear_n));
    cover property ($fell(load_dac_n) && sync_n);
endmodule // odc_ctrl_checker

bind odc_ctrl odc_ctrl_checker i_odc_ctrl_checker (.mclk(mclk),
    .rst_n(rst_n), .sync_n(sync_n), .load_dac_n(load_dac_n),
    .clear_n(clear_n), .reference_enable_r(reference_enable_r),
    .clear_code_select_r(clear_code_select_r),
    .load_override_mask_r(load_override_mask_r),
    .pwrdn_mode_r(pwrdn_mode_r), .dac_code_r(dac_code_r),
    .frame_done_r(frame_done_r));

// File: testbench/odc_host.sv
/* Host model driving the serial link of odc_ctrl.
   Assumes the device samples the link with a much faster clock. */
`timescale 1ns/100ps
module odc_host (
    // serial link toward the device
    output logic sclk,
    output logic sync_n,
    output logic sdin
);
    initial begin
        sclk = 1;
        sync_n = 1;
        sdin = 0;
    end
    // msb first; fewer than 32 bits models an aborted frame
    task automatic send(input logic [31:0] f, input int n);
        #3 sync_n = 0;
        for (int i = 0; i < n; i++) begin
            sdin = f[31-i];
            #32 sclk = 0;
            #32 sclk = 1;
        end
        #100 sync_n = 1;
        // released line must not keep showing the last bit
        sdin = ~sdin;
        #100;
    endtask
endmodule // odc_host

// File: testbench/test_odc_ctrl.sv
/* Self-checking bench for odc_ctrl with a serial host model.
   Assumes the 200 MHz clock and a 64 ns serial clock. */
`timescale 1ns/100ps
module test_odc_ctrl;
    logic mclk = 0;
    logic rst_n = 0;
    logic load_dac_n = 1;
    logic clear_n = 1;
    wire sclk, sync_n, sdin;
    logic ref_en, done;
    logic [1:0] code;
    logic [7:0] mask, sel;
    logic [15:0] pwr, exp_pwr = '0;
    logic [127:0] dac, exp_dac = '0;
    int n_mismatch = 0;
    int checks = 0;
    int n_done = 0;
    odc_ctrl i_odc_ctrl (.mclk(mclk), .rst_n(rst_n), .sclk(sclk),
        .sync_n(sync_n), .sdin(sdin), .load_dac_n(load_dac_n),
        .clear_n(clear_n), .reference_enable_r(ref_en),
        .clear_code_select_r(code), .load_override_mask_r(mask),
        .pwrdn_mode_r(pwr), .dac_code_r(dac), .frame_done_r(done));
    odc_host i_odc_host (.sclk(sclk), .sync_n(sync_n), .sdin(sdin));
    always #2.5 mclk = ~mclk;
    // counted away from the edge that launches the pulse
    always @(negedge mclk) begin
        if (done === 1'b1) n_done++;
    end
    function automatic logic [31:0] fr(logic [3:0] c, logic [3:0] a,
        logic [19:0] d);
        return {4'ha, c, a, d};
    endfunction
    task automatic chk(string nm, logic [127:0] e, logic [127:0] g);
        checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic pin(bit clr);
        @(posedge mclk) #1;
        if (clr) clear_n = 0;
        else load_dac_n = 0;
        repeat (10) @(posedge mclk);
        #1 clear_n = 1;
        load_dac_n = 1;
        repeat (10) @(posedge mclk);
    endtask
    task automatic final_report;
        $display("mismatches %0d checks %0d", n_mismatch, checks);
        if (n_mismatch == 0 && checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    initial begin
        #200000;
        n_mismatch++;
        final_report();
    end
    initial begin
        repeat (10) @(posedge mclk);
        #1 rst_n = 1;
        repeat (8) @(posedge mclk);
        chk("ref", 1'b0, ref_en);
        chk("mask", 8'h00, mask);
        i_odc_host.send(fr(odc_pkg::CMD_REF, 4'h5, 20'hffffe), 32);
        chk("ref", 1'b0, ref_en);
        i_odc_host.send(fr(odc_pkg::CMD_REF, 4'h5, 20'h00001), 32);
        chk("ref", 1'b1, ref_en);
        for (int m = 0; m < 4; m++) begin
            sel = 8'h0f << m;
            i_odc_host.send(fr(odc_pkg::CMD_POWER, 4'h3,
                {10'h3ff, m[1:0], sel}), 32);
            for (int n = 0; n < 8; n++) begin
                if (sel[n]) exp_pwr[2*n +: 2] = m[1:0];
            end
            chk("pwr", exp_pwr, pwr);
        end
        // pin held low across the frame selects synchronous load
        @(posedge mclk) #1 load_dac_n = 0;
        i_odc_host.send(fr(odc_pkg::CMD_WRITE_IN, 4'hf, 20'h12340), 32);
        exp_dac = {8{16'h1234}};
        chk("dac", exp_dac, dac);
        @(posedge mclk) #1 load_dac_n = 1;
        for (int c = 3; c >= 0; c--) begin
            i_odc_host.send(fr(odc_pkg::CMD_CLR_CODE, 4'h9,
                {18'h3ffff, c[1:0]}), 32);
            chk("code", c[1:0], code);
            pin(1);
            if (c == 2) exp_dac = {8{odc_pkg::CODE_FULL}};
            if (c == 1) exp_dac = {8{odc_pkg::CODE_MID}};
            if (c == 0) exp_dac = {8{odc_pkg::CODE_ZERO}};
            chk("dac", exp_dac, dac);
        end
        // 31 bits: a commit one edge early would load ff as mask
        i_odc_host.send(fr(4'hc, 4'h0, 20'h001fe), 31);
        chk("mask", 8'h00, mask);
        i_odc_host.send(fr(odc_pkg::CMD_MASK, 4'h0, 20'hfff05), 32);
        chk("mask", 8'h05, mask);
        i_odc_host.send(fr(odc_pkg::CMD_WRITE_IN, 4'h0, 20'haaaa0), 32);
        exp_dac[15:0] = 16'haaaa;
        chk("dac", exp_dac, dac);
        i_odc_host.send(fr(odc_pkg::CMD_WRITE_IN, 4'h1, 20'h55550), 32);
        chk("dac", exp_dac, dac);
        pin(0);
        exp_dac[31:16] = 16'h5555;
        chk("dac", exp_dac, dac);
        i_odc_host.send(fr(odc_pkg::CMD_WRITE_IN, 4'h3, 20'h33330), 32);
        i_odc_host.send(fr(odc_pkg::CMD_WRITE_ALL, 4'h4, 20'h44440), 32);
        exp_dac[79:48] = 32'h4444_3333;
        chk("dac", exp_dac, dac);
        i_odc_host.send(fr(odc_pkg::CMD_WRITE_UPD, 4'h5, 20'h66660), 32);
        exp_dac[95:80] = 16'h6666;
        chk("dac", exp_dac, dac);
        i_odc_host.send(fr(odc_pkg::CMD_WRITE_IN, 4'h6, 20'h77770), 32);
        i_odc_host.send(fr(odc_pkg::CMD_UPDATE_N, 4'h6, 20'h00000), 32);
        exp_dac[111:96] = 16'h7777;
        chk("dac", exp_dac, dac);
        i_odc_host.send(fr(odc_pkg::CMD_RESET, 4'h0, 20'h00000), 32);
        chk("ref", 1'b0, ref_en);
        chk("mask", 8'h00, mask);
        chk("frames", 20, n_done);
        final_report();
    end
endmodule // test_odc_ctrl
